//--- oad_decoder.v
// Operand addressing decoder: opcode, page prefix, postbyte, extensions.
// Assumes one program byte per cycle when byte_valid_i is high, the
// opcode class table supplied as class_i for the current opcode byte,
// and register and memory word values supplied by the core.
// The core holds its registers steady for a whole instruction, and
// answers each pointer request with ptr_valid_i some cycles later.
`timescale 1ns/1ps
`include "oad_defs.vh"
module oad_decoder (
   input wire clk_i,
   input wire nrst_i,
   input wire byte_valid_i,
   input wire [7:0] byte_i,
   input wire [2:0] class_i,
   input wire [15:0] pc_i,
   input wire [15:0] x_i,
   input wire [15:0] y_i,
   input wire [15:0] sp_i,
   input wire [15:0] acc_d_i,
   input wire ptr_valid_i,
   input wire [15:0] ptr_word_i,
   output wire byte_ready_o,
   output reg [7:0] opcode_o,
   output reg page2_o,
   output reg [7:0] post_raw_o,
   output reg [10:0] mode_o,
   output reg [15:0] ea_o,
   output reg [15:0] literal_o,
   output reg ea_valid_o,
   output reg done_o,
   output reg bad_index_o,
   output reg upd_o,
   output reg [1:0] upd_reg_o,
   output reg [15:0] upd_val_o,
   output reg ptr_req_o,
   output reg [15:0] ptr_addr_o
);
   // One-hot states; ST_EXT1 doubles as the idle cycle for
   // indexed forms that carry no extension byte
   localparam ST_OPC = 6'h01;
   localparam ST_POST = 6'h02;
   localparam ST_EXT1 = 6'h04;
   localparam ST_EXT2 = 6'h08;
   localparam ST_PTR = 6'h10;
   localparam ST_DONE = 6'h20;

   reg [5:0] state;
   reg [2:0] cls;
   reg [7:0] hi;
   reg [7:0] post;
   reg [1:0] left;
   reg [5:0] next_state;

   wire [1:0] br_sel;
   wire [1:0] ao_sel;
   wire [10:0] form;
   wire [1:0] ext_n;
   wire [15:0] coff;
   wire apost;
   wire abad;
   wire [15:0] jw_word;
   wire [15:0] jw_sum;
   reg [15:0] base;
   reg [15:0] acc_off;
   wire [15:0] short_ea;
   wire [15:0] acc_ea;
   wire [15:0] rel8_ea;
   wire [15:0] nine_ea;
   wire no_ext;

   // Postbyte field split; the stored postbyte keeps the fields steady
   // while the extension bytes stream past
   oad_postbyte_dec u_pb (
      .index_postbyte_i(post),
      .base_register_select_o(br_sel),
      .acc_offset_select_o(ao_sel),
      .form_o(form),
      .ext_bytes_o(ext_n),
      .const_off_o(coff),
      .auto_post_o(apost),
      .auto_bad_o(abad)
   );

   // Big-endian join of held high byte and incoming low byte
   oad_word_join u_jw (
      .hi_i(hi),
      .lo_i(byte_i),
      .base_i(cls == `OAD_C_IDX ? base : pc_i),
      .word_o(jw_word),
      .sum_o(jw_sum)
   );

   // Base register choice
   // PC is a legal base for every form except automatic update
   always @* begin
      case (br_sel)
         `OAD_BR_X: base = x_i;
         `OAD_BR_Y: base = y_i;
         `OAD_BR_SP: base = sp_i;
         default: base = pc_i;
      endcase
   end

   // Unsigned accumulator offset
   // A is the high byte of D and B the low byte, both zero-extended
   always @* begin
      case (ao_sel)
         `OAD_AO_A: acc_off = {8'h00, acc_d_i[15:8]};
         `OAD_AO_B: acc_off = {8'h00, acc_d_i[7:0]};
         default: acc_off = acc_d_i;
      endcase
   end

   // Address sums, all wrapping in 16 bits
   // The nine-bit sum ORs this byte into the sign-filled offset
   assign short_ea = base + coff;
   assign acc_ea = base + acc_off;
   assign rel8_ea = pc_i + {{8{byte_i[7]}}, byte_i};
   assign nine_ea = base + (coff | {8'h00, byte_i});

   // Bytes are accepted except while waiting for a pointer or done, and
   // in the idle extension cycle of an indexed form that needs no byte;
   // offering ready there would swallow the next opcode unseen
   assign no_ext = (cls == `OAD_C_IDX) && (ext_n == 2'h0);
   assign byte_ready_o = state[0] | state[1] | state[3] |
      (state[2] & ~no_ext);

   // Next state
   always @* begin
      next_state = state;
      case (state)
         ST_OPC: begin
            // A prefix right after a prefix is decoded as an opcode
            if (byte_valid_i &&
               (byte_i != `OAD_PAGE2_PREFIX || page2_o)) begin
               case (class_i)
                  `OAD_C_REG: next_state = ST_DONE;
                  `OAD_C_IDX: next_state = ST_POST;
                  `OAD_C_LIT16,
                  `OAD_C_FULL,
                  `OAD_C_REL16: next_state = ST_EXT1;
                  default: next_state = ST_EXT2;
               endcase
            end
         end
         ST_POST: begin
            if (byte_valid_i)
               next_state = ST_EXT1;
         end
         ST_EXT1: begin
            // The byte count comes from the stored postbyte itself
            if (cls == `OAD_C_IDX && ext_n == 2'h0) begin
               next_state = form[10] ? ST_PTR : ST_DONE;
            end else if (byte_valid_i) begin
               // The nine-bit offset has its only byte here
               if (cls == `OAD_C_IDX && ext_n == 2'h1)
                  next_state = ST_DONE;
               else
                  next_state = ST_EXT2;
            end
         end
         ST_EXT2: begin
            // Last byte; pointer forms go on to the memory read
            if (byte_valid_i)
               next_state = (cls == `OAD_C_IDX && form[10]) ?
                  ST_PTR : ST_DONE;
         end
         ST_PTR: begin
            if (ptr_valid_i)
               next_state = ST_DONE;
         end
         ST_DONE: next_state = ST_OPC;
         default: next_state = ST_OPC;
      endcase
   end

   // Datapath and outputs. Results stand from the edge after the last
   // byte or pointer word until the next opcode is taken; done_o follows one cycle
   // later, so a reader may sample both together.
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         // Start as a finished register-only decode
         state <= ST_OPC;
         cls <= `OAD_C_REG;
         hi <= 8'h00;
         post <= 8'h00;
         left <= 2'h0;
         opcode_o <= 8'h00;
         page2_o <= 1'b0;
         post_raw_o <= 8'h00;
         mode_o <= `OAD_M_REG;
         ea_o <= `OAD_EA_RST;
         literal_o <= 16'h0000;
         ea_valid_o <= 1'b0;
         done_o <= 1'b0;
         bad_index_o <= 1'b0;
         upd_o <= 1'b0;
         upd_reg_o <= 2'h0;
         upd_val_o <= 16'h0000;
         ptr_req_o <= 1'b0;
         ptr_addr_o <= 16'h0000;
      end else begin
         state <= next_state;
         done_o <= 1'b0;
         upd_o <= 1'b0;
         case (state)
            ST_OPC: begin
               if (byte_valid_i) begin
                  if (byte_i == `OAD_PAGE2_PREFIX && !page2_o) begin
                     page2_o <= 1'b1;
                  end else begin
                     opcode_o <= byte_i;
                     cls <= class_i;
                     // The last results stand until this new opcode
                     hi <= 8'h00;
                     ea_valid_o <= 1'b0;
                     bad_index_o <= 1'b0;
                     literal_o <= 16'h0000;
                     case (class_i)
                        `OAD_C_REG: mode_o <= `OAD_M_REG;
                        `OAD_C_LIT8,
                        `OAD_C_LIT16: mode_o <= `OAD_M_LIT;
                        `OAD_C_DIR: mode_o <= `OAD_M_DIR;
                        `OAD_C_FULL: mode_o <= `OAD_M_FULL;
                        `OAD_C_IDX: mode_o <= `OAD_M_SHORT;
                        default: mode_o <= `OAD_M_REL;
                     endcase
                  end
               end
            end
            ST_POST: begin
               if (byte_valid_i) begin
                  post <= byte_i;
                  post_raw_o <= byte_i;
               end
            end
            ST_EXT1: begin
               if (cls == `OAD_C_IDX) begin
                  mode_o <= form;
                  left <= ext_n;
                  if (ext_n == 2'h0) begin
                     // Forms needing no extension bytes
                     if (form == `OAD_M_SHORT) begin
                        ea_o <= short_ea;
                        ea_valid_o <= 1'b1;
                     end else if (form == `OAD_M_AUTO) begin
                        // Post form uses the old base; core writes back
                        bad_index_o <= abad;
                        ea_o <= apost ? base : short_ea;
                        ea_valid_o <= ~abad;
                        upd_o <= ~abad;
                        upd_reg_o <= br_sel;
                        upd_val_o <= short_ea;
                     end else if (form == `OAD_M_ACC) begin
                        ea_o <= acc_ea;
                        ea_valid_o <= 1'b1;
                     end else begin
                        ptr_addr_o <= acc_ea;
                        ptr_req_o <= 1'b1;
                     end
                  end else if (byte_valid_i) begin
                     hi <= byte_i;
                     // Nine-bit form: sign from postbyte, low bits here
                     if (ext_n == 2'h1) begin
                        ea_o <= nine_ea;
                        ea_valid_o <= 1'b1;
                     end
                  end
               end else if (byte_valid_i) begin
                  hi <= byte_i;
               end
            end
            ST_EXT2: begin
               if (byte_valid_i) begin
                  case (cls)
                     `OAD_C_LIT8: literal_o <= {8'h00, byte_i};
                     `OAD_C_LIT16: literal_o <= jw_word;
                     `OAD_C_DIR: begin
                        ea_o <= {8'h00, byte_i};
                        ea_valid_o <= 1'b1;
                     end
                     `OAD_C_FULL: begin
                        ea_o <= jw_word;
                        ea_valid_o <= 1'b1;
                     end
                     `OAD_C_REL8: begin
                        ea_o <= rel8_ea;
                        ea_valid_o <= 1'b1;
                     end
                     `OAD_C_REL16: begin
                        ea_o <= jw_sum;
                        ea_valid_o <= 1'b1;
                     end
                     `OAD_C_IDX: begin
                        if (form[10]) begin
                           ptr_addr_o <= jw_sum;
                           ptr_req_o <= 1'b1;
                        end else if (left == 2'h2) begin
                           ea_o <= jw_sum;
                           ea_valid_o <= 1'b1;
                        end
                     end
                     default: ea_valid_o <= 1'b0;
                  endcase
               end
            end
            ST_PTR: begin
               // The request and its address stand until the word arrives
               if (ptr_valid_i) begin
                  ptr_req_o <= 1'b0;
                  ea_o <= ptr_word_i;
                  ea_valid_o <= 1'b1;
               end
            end
            ST_DONE: begin
               // The page flag lasts for one instruction only
               done_o <= 1'b1;
               page2_o <= 1'b0;
            end
            default: ea_valid_o <= 1'b0;
         endcase
      end
   end
endmodule // oad_decoder

//--- oad_defs.vh
// Constants for the operand addressing decoder.
// Assumes inclusion by bare name from the design files.
`ifndef OAD_DEFS_VH
`define OAD_DEFS_VH
// Opcode page prefix byte
`define OAD_PAGE2_PREFIX 8'h18
// Addressing modes (one-hot codes on the mode output)
`define OAD_MODE_W 11
`define OAD_M_REG 11'h001
`define OAD_M_LIT 11'h002
`define OAD_M_DIR 11'h004
`define OAD_M_FULL 11'h008
`define OAD_M_REL 11'h010
`define OAD_M_SHORT 11'h020
`define OAD_M_AUTO 11'h040
`define OAD_M_ACC 11'h080
`define OAD_M_NINE 11'h100
`define OAD_M_SIXTEEN 11'h200
`define OAD_M_IND 11'h400
// Opcode class codes from the class table
`define OAD_C_REG 3'h0
`define OAD_C_LIT8 3'h1
`define OAD_C_LIT16 3'h2
`define OAD_C_DIR 3'h3
`define OAD_C_FULL 3'h4
`define OAD_C_REL8 3'h5
`define OAD_C_REL16 3'h6
`define OAD_C_IDX 3'h7
// Base register select codes
`define OAD_BR_X 2'h0
`define OAD_BR_Y 2'h1
`define OAD_BR_SP 2'h2
`define OAD_BR_PC 2'h3
// Accumulator offset select codes
`define OAD_AO_A 2'h0
`define OAD_AO_B 2'h1
`define OAD_AO_D 2'h2
`define OAD_AO_DIND 2'h3
// Reset value of the effective address
`define OAD_EA_RST 16'h0000
`endif

//--- oad_fetch_model.sv
// Fetch queue and memory word model on the far side of the decoder.
// Assumes the bench pushes {class, byte} entries into q.
`timescale 1ns/1ps
module oad_fetch_model (
   input wire clk_i,
   input wire byte_ready_i,
   input wire ptr_req_i,
   input wire [15:0] ptr_addr_i,
   output reg byte_valid_o,
   output reg [7:0] byte_o,
   output reg [2:0] class_o,
   output reg ptr_valid_o,
   output reg [15:0] ptr_word_o
);
   logic [10:0] q[$];
   int cyc = 0;
   int wt = 0;
   int dly = 0;
   // Memory contents seen through pointer reads
   function automatic [15:0] ptr_fn(input [15:0] a);
      ptr_fn = a ^ 16'hc3a5;
   endfunction
   initial begin
      {byte_valid_o, byte_o, class_o, ptr_valid_o, ptr_word_o} = '0;
   end
   // Offer bytes with stalls, answer pointer reads fast or slow
   always @(posedge clk_i) begin : drv
      logic tk;
      tk = byte_valid_o && byte_ready_i;
      if (tk) void'(q.pop_front());
      #1;
      cyc++;
      if (!byte_valid_o || tk) byte_valid_o = q.size() > 0 && cyc % 5 != 0;
      if (byte_valid_o) {class_o, byte_o} = q[0];
      else {class_o, byte_o} = {cyc[2:0], ~cyc[7:0]}; // Idle bus churns
      if (ptr_valid_o) ptr_valid_o = 1'b0;
      else if (ptr_req_i && wt >= dly) begin
         ptr_valid_o = 1'b1;
         ptr_word_o = ptr_fn(ptr_addr_i);
         wt = 0;
         dly = 3 - dly;
      end else begin
         if (ptr_req_i) wt++;
         ptr_word_o = ~ptr_word_o;
      end
   end
endmodule // oad_fetch_model

//--- oad_monitor.sv
// Checker for the operand addressing decoder top-level ports.
// Assumes core register inputs stay stable during each instruction.
`timescale 1ns/1ps
`include "oad_defs.vh"
module oad_monitor (
   input wire clk_i,
   input wire nrst_i,
   input wire byte_ready_o,
   input wire done_o,
   input wire [10:0] mode_o,
   input wire [15:0] ea_o,
   input wire ea_valid_o,
   input wire [7:0] post_raw_o,
   input wire [15:0] pc_i,
   input wire [15:0] x_i,
   input wire [15:0] y_i,
   input wire [15:0] sp_i,
   input wire [15:0] acc_d_i,
   input wire upd_o,
   input wire [1:0] upd_reg_o,
   input wire [15:0] upd_val_o,
   input wire bad_index_o,
   input wire ptr_req_o,
   input wire ptr_valid_i,
   input wire [15:0] ptr_addr_o,
   input wire page2_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // Base, step and offset values seen by the current postbyte
   wire [1:0] rs = post_raw_o[7:5] == 3'h7 ? post_raw_o[4:3] :
      post_raw_o[7:6];
   wire [15:0] pbase = rs == 2'h0 ? x_i : rs == 2'h1 ? y_i :
      rs == 2'h2 ? sp_i : pc_i;
   wire [15:0] ubase = upd_reg_o == 2'h0 ? x_i :
      upd_reg_o == 2'h1 ? y_i : sp_i;
   wire [15:0] stp = post_raw_o[3] ? {12'hfff, post_raw_o[3:0]} :
      {12'h000, post_raw_o[3:0]} + 16'h0001;
   wire [15:0] s5 = {{11{post_raw_o[4]}}, post_raw_o[4:0]};
   wire [15:0] aoff = post_raw_o[1:0] == 2'h0 ? {8'h00, acc_d_i[15:8]} :
      post_raw_o[1:0] == 2'h1 ? {8'h00, acc_d_i[7:0]} : acc_d_i;
   AST_DIR_HIGH_ZERO: assert property (
      ea_valid_o && mode_o == `OAD_M_DIR |-> ea_o[15:8] == 8'h00)
      else $error("direct high byte set");
   AST_REG_NO_EA: assert property (
      done_o && mode_o == `OAD_M_REG |-> !ea_valid_o)
      else $error("reg-only formed address");
   AST_DONE_PULSE: assert property (done_o |=> !done_o)
      else $error("done longer than a cycle");
   AST_REFUSE_DONE: assert property (done_o |-> !$past(byte_ready_o))
      else $error("byte accepted in done state");
   AST_UPD_VAL: assert property (upd_o |-> upd_val_o == ubase + stp)
      else $error("wrong updated base");
   AST_UPD_NOT_PC: assert property (upd_o |-> upd_reg_o != 2'h3)
      else $error("pc auto updated");
   AST_BAD_NO_UPD: assert property (bad_index_o |-> !upd_o)
      else $error("update on bad index");
   AST_SHORT_EA: assert property (
      $rose(ea_valid_o) && mode_o == `OAD_M_SHORT |-> ea_o == pbase + s5)
      else $error("short offset address");
   AST_ACC_EA: assert property (
      $rose(ea_valid_o) && mode_o == `OAD_M_ACC |-> ea_o == pbase + aoff)
      else $error("accumulator offset address");
   AST_AUTO_EA: assert property (
      $rose(ea_valid_o) && mode_o == `OAD_M_AUTO
      |-> ea_o == (post_raw_o[4] ? pbase : pbase + stp))
      else $error("auto update address");
   AST_PTR_HOLD: assert property (
      ptr_req_o && !ptr_valid_i |=> ptr_req_o && $stable(ptr_addr_o))
      else $error("pointer request dropped");
   // Main scenarios reached
   C_UPD: cover property (upd_o);
   C_PTR: cover property (ptr_req_o && ptr_valid_i);
   C_PAGE2: cover property (page2_o);
endmodule // oad_monitor

//--- oad_postbyte_dec.v
// Splits an index postbyte into its form, base, offset and byte count.
// Assumes a whole postbyte is presented; purely combinational.
`timescale 1ns/1ps
`include "oad_defs.vh"
module oad_postbyte_dec (
   input wire [7:0] index_postbyte_i,
   output reg [1:0] base_register_select_o,
   output reg [1:0] acc_offset_select_o,
   output reg [10:0] form_o,
   output reg [1:0] ext_bytes_o,
   output reg [15:0] const_off_o,
   output reg auto_post_o,
   output reg auto_bad_o
);
   // Classify the postbyte pattern
   always @* begin
      base_register_select_o = index_postbyte_i[7:6];
      acc_offset_select_o = index_postbyte_i[1:0];
      form_o = `OAD_M_SHORT;
      ext_bytes_o = 2'h0;
      const_off_o = {{11{index_postbyte_i[4]}}, index_postbyte_i[4:0]};
      auto_post_o = 1'b0;
      auto_bad_o = 1'b0;
      if (!index_postbyte_i[5]) begin
         form_o = `OAD_M_SHORT;
      end else if (index_postbyte_i[7:5] != 3'h7) begin
         // Auto update: n is 1..8 up for 0nnn, down for 1nnn
         form_o = `OAD_M_AUTO;
         auto_post_o = index_postbyte_i[4];
         auto_bad_o = (index_postbyte_i[7:6] == `OAD_BR_PC);
         if (index_postbyte_i[3])
            const_off_o = {{12{1'b1}}, index_postbyte_i[3:0]};
         else
            const_off_o = {12'h000, index_postbyte_i[3:0]} + 16'h0001;
      end else begin
         base_register_select_o = index_postbyte_i[4:3];
         if (index_postbyte_i[2]) begin
            form_o = (index_postbyte_i[1:0] == `OAD_AO_DIND) ?
               `OAD_M_IND : `OAD_M_ACC;
         end else if (index_postbyte_i[1:0] == 2'h3) begin
            form_o = `OAD_M_IND;
            ext_bytes_o = 2'h2;
         end else if (index_postbyte_i[1]) begin
            form_o = `OAD_M_SIXTEEN;
            ext_bytes_o = 2'h2;
         end else begin
            form_o = `OAD_M_NINE;
            ext_bytes_o = 2'h1;
            const_off_o = {{8{index_postbyte_i[0]}}, 8'h00};
         end
      end
   end
endmodule // oad_postbyte_dec

//--- oad_word_join.v
// Joins two bytes into a big-endian word and adds a base, wrapping.
// Assumes the caller holds both bytes stable while it samples the sum.
`timescale 1ns/1ps
module oad_word_join (
   input wire [7:0] hi_i,
   input wire [7:0] lo_i,
   input wire [15:0] base_i,
   output wire [15:0] word_o,
   output wire [15:0] sum_o
);
   // More significant byte came from the lower address
   assign word_o = {hi_i, lo_i};
   assign sum_o = base_i + {hi_i, lo_i};
endmodule // oad_word_join

//--- operand_addressing_decoder_tb.sv
// Self-checking bench: random instructions of every addressing form.
// Assumes the decoder, fetch model and monitor files are compiled first.
`timescale 1ns/1ps
`include "oad_defs.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
   $display("ERROR %0t: got %h want %h", $time, a, b); end end
module operand_addressing_decoder_tb;
   reg clk = 0, nrst = 0;
   reg [15:0] pc = 0, x = 0, y = 0, sp = 0, d = 0;
   wire bv, rdy, done, pv, ev, bad, upd, preq, pg2;
   wire [7:0] b, op, pb_o;
   wire [2:0] cls;
   wire [15:0] pw, ea, lit, uv, pa;
   wire [10:0] mode;
   wire [1:0] ur;
   int mismatches = 0, compares = 0, i, k;
   reg pg_seen = 0;
   reg [31:0] rs = 32'd83534;
   typedef struct {logic [10:0] m; logic [7:0] op; logic [15:0] v;
      int w; logic p;} exp_t;
   exp_t exp_q[$], e;
   initial forever #2 clk = ~clk;
   oad_decoder i_oad_decoder (.clk_i(clk), .nrst_i(nrst),
      .byte_valid_i(bv), .byte_i(b), .class_i(cls), .pc_i(pc), .x_i(x),
      .y_i(y), .sp_i(sp), .acc_d_i(d), .ptr_valid_i(pv), .ptr_word_i(pw),
      .byte_ready_o(rdy), .opcode_o(op), .page2_o(pg2), .post_raw_o(pb_o),
      .mode_o(mode), .ea_o(ea), .literal_o(lit), .ea_valid_o(ev),
      .done_o(done), .bad_index_o(bad), .upd_o(upd), .upd_reg_o(ur),
      .upd_val_o(uv), .ptr_req_o(preq), .ptr_addr_o(pa));
   oad_fetch_model i_oad_fetch_model (.clk_i(clk), .byte_ready_i(rdy),
      .ptr_req_i(preq), .ptr_addr_i(pa), .byte_valid_o(bv), .byte_o(b),
      .class_o(cls), .ptr_valid_o(pv), .ptr_word_o(pw));
   function automatic [31:0] rnd();
      rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
      rnd = rs;
   endfunction
   function automatic [15:0] bs(input [1:0] r);
      bs = r == 2'h0 ? x : r == 2'h1 ? y : r == 2'h2 ? sp : pc;
   endfunction
   task give_verdict();
      if (mismatches == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Queue the bytes of one instruction, note the result, await done
   task ins(input [2:0] c, input [7:0] o, input idx, input [7:0] pb,
      input [1:0] nx, input [15:0] ex, input [10:0] m, input [15:0] v,
      input int w, input pre);
      if (pre) i_oad_fetch_model.q.push_back({3'h0, 8'h18});
      i_oad_fetch_model.q.push_back({c, o});
      if (idx) i_oad_fetch_model.q.push_back({3'h0, pb});
      if (nx == 2) i_oad_fetch_model.q.push_back({3'h0, ex[15:8]});
      if (nx != 0) i_oad_fetch_model.q.push_back({3'h0, ex[7:0]});
      exp_q.push_back('{m, o, v, w, pre});
      for (k = 0; k < 80 && done !== 1'b1; k++) @(negedge clk);
      if (k == 80) `CHK(1'b0, 1'b1)
      @(negedge clk);
   endtask
   // The page flag only stands while its instruction is under way
   always @(negedge clk) if (pg2 === 1'b1) pg_seen = 1'b1;
   // Compare each finished decode against the oldest note
   always @(negedge clk) if (done === 1'b1) begin
      if (exp_q.size() == 0) `CHK(1'b0, 1'b1)
      else begin
         e = exp_q.pop_front();
         `CHK(mode, e.m)
         `CHK(op, e.op)
         `CHK(pg_seen, e.p)
         `CHK(ev, e.w == 1)
         `CHK(bad, 1'b0)
         if (e.w == 1) `CHK(ea, e.v)
         if (e.w == 2) `CHK(lit, e.v)
         if (e.w == 3) `CHK(lit[7:0], e.v[7:0])
      end
      pg_seen = 1'b0;
   end
   initial begin
      #80000;
      mismatches++;
      give_verdict();
   end
   // Main sequence over every addressing form
   initial begin : main
      reg [7:0] o, pb;
      reg [15:0] ex, bse, v;
      reg [1:0] rr;
      repeat (4) @(posedge clk);
      #1 nrst = 1;
      for (i = 0; i < 150; i++) begin
         @(posedge clk);
         #1;
         {x, y} = rnd();
         {sp, pc} = rnd();
         d = rnd();
         o = rnd() | 8'h01;
         ex = rnd();
         pb = rnd();
         rr = pb[7:6] == 2'h3 ? 2'h2 : pb[7:6];
         bse = bs(pb[7:6]);
         case (i % 15)
         0: ins(`OAD_C_REG, o, 0, 0, 0, 0, `OAD_M_REG, 0, 0, i[4]);
         1: ins(`OAD_C_LIT8, o, 0, 0, 1, ex, `OAD_M_LIT, ex, 3, i[4]);
         2: ins(`OAD_C_LIT16, o, 0, 0, 2, ex, `OAD_M_LIT, ex, 2, i[4]);
         3: ins(`OAD_C_DIR, o, 0, 0, 1, ex, `OAD_M_DIR, {8'h00, ex[7:0]},
            1, i[4]);
         4: ins(`OAD_C_FULL, o, 0, 0, 2, ex, `OAD_M_FULL, ex, 1, i[4]);
         5: ins(`OAD_C_REL8, o, 0, 0, 1, ex, `OAD_M_REL,
            pc + {{8{ex[7]}}, ex[7:0]}, 1, i[4]);
         6: ins(`OAD_C_REL16, o, 0, 0, 2, ex, `OAD_M_REL, pc + ex, 1, i[4]);
         7: ins(`OAD_C_IDX, o, 1, {pb[7:6], 1'b0, pb[4:0]}, 0, 0,
            `OAD_M_SHORT, bse + {{11{pb[4]}}, pb[4:0]}, 1, i[4]);
         8: begin
            v = pb[3] ? {12'hfff, pb[3:0]} : {12'h000, pb[3:0]} + 16'h1;
            ins(`OAD_C_IDX, o, 1, {rr, 1'b1, pb[4:0]}, 0, 0, `OAD_M_AUTO,
               pb[4] ? bs(rr) : bs(rr) + v, 1, i[4]);
         end
         9: ins(`OAD_C_IDX, o, 1, {3'h7, pb[4:3], 2'h0, pb[0]}, 1, ex,
            `OAD_M_NINE, bs(pb[4:3]) + {{8{pb[0]}}, ex[7:0]}, 1, i[4]);
         10: ins(`OAD_C_IDX, o, 1, {3'h7, pb[4:3], 3'h2}, 2, ex,
            `OAD_M_SIXTEEN, bs(pb[4:3]) + ex, 1, i[4]);
         11: ins(`OAD_C_IDX, o, 1, {3'h7, pb[4:3], 3'h3}, 2, ex, `OAD_M_IND,
            i_oad_fetch_model.ptr_fn(bs(pb[4:3]) + ex), 1, i[4]);
         12: begin
            v = pb[1] ? d : pb[0] ? {8'h00, d[7:0]} : {8'h00, d[15:8]};
            ins(`OAD_C_IDX, o, 1, {3'h7, pb[4:3], 1'b1, pb[1],
               pb[0] & ~pb[1]}, 0, 0, `OAD_M_ACC, bs(pb[4:3]) + v, 1,
               i[4]);
         end
         13: ins(`OAD_C_IDX, o, 1, {3'h7, pb[4:3], 3'h7}, 0, 0, `OAD_M_IND,
            i_oad_fetch_model.ptr_fn(bs(pb[4:3]) + d), 1, i[4]);
         default: ins(`OAD_C_IDX, o, 1, {3'h6, pb[4:0]}, 0, 0, `OAD_M_SHORT,
            pc + {{11{pb[4]}}, pb[4:0]}, 1, i[4]);
         endcase
      end
      give_verdict();
   end
endmodule // operand_addressing_decoder_tb
bind oad_decoder oad_monitor i_oad_monitor (.clk_i, .nrst_i, .byte_ready_o,
   .done_o, .mode_o, .ea_o, .ea_valid_o, .post_raw_o, .pc_i, .x_i, .y_i,
   .sp_i, .acc_d_i, .upd_o, .upd_reg_o, .upd_val_o, .bad_index_o,
   .ptr_req_o, .ptr_valid_i, .ptr_addr_o, .page2_o);
